// ### include/rx_stream_consts.svh
// constants for the segmented receive frame stream output stage
// assumes inclusion by bare name from the package and the design file
`ifndef RX_STREAM_CONSTS_SVH
`define RX_STREAM_CONSTS_SVH

// data bus and segment geometry
`define RX_BUS_W        128
`define RX_SEG_COUNT    2
`define RX_SEG_W        64
`define RX_SEG_BYTES    8
`define RX_EMPTY_W      3

// reset values
`define RX_EMPTY_NONE   3'h0
`define RX_DATA_RESET   64'h0

// reset synchroniser depth
`define RX_RST_STAGES   2

`endif

// ### include/rx_stream_pkg.sv
// types for the segmented receive frame stream output stage
// assumes rx_stream_consts.svh is on the include path
`include "rx_stream_consts.svh"

package rx_stream_pkg;

    // one segment as handed over by the frame decoder
    typedef struct packed {
        logic                     valid;
        logic                     start;
        logic                     last;
        logic [`RX_EMPTY_W-1:0]   empty;
        logic                     fcs_bad;
        logic                     len_bad;
        logic                     code_bad;
        logic [`RX_SEG_W-1:0]     data;
    } seg_in_s;

    // one segment as presented to the client
    typedef struct packed {
        logic                     en;
        logic                     start;
        logic                     last;
        logic                     bad;
        logic [`RX_EMPTY_W-1:0]   empty;
        logic [`RX_SEG_W-1:0]     data;
    } seg_out_s;

    typedef seg_in_s  [`RX_SEG_COUNT-1:0] seg_in_pair_t;
    typedef seg_out_s [`RX_SEG_COUNT-1:0] seg_out_pair_t;

endpackage

// ### hw/rx_segmented_frame_stream.sv
// receive-side client stream: two 64-bit segments with per-segment qualifiers
// assumes a decoder upstream delivering frame segments in stream order, synchronous
// to SYS_CLK, with fcs and length checks valid on the segment that ends a frame
`timescale 1ns/1ps
`include "rx_stream_consts.svh"

module rx_segmented_frame_stream #(
    parameter int SEG_W     = `RX_SEG_W,
    parameter int SEG_COUNT = `RX_SEG_COUNT
) (
    // clock and resets
    input  wire logic                         SYS_CLK,
    input  wire logic                         RESETN,
    input  wire logic                         RX_RESET,
    // decoder side
    input  wire rx_stream_pkg::seg_in_pair_t  IN_SEG,
    // client stream
    output logic [`RX_BUS_W-1:0]              RX_DATA,
    output logic                              RX_VALID,
    output logic                              SEGMENT0_ENABLE,
    output logic                              SEGMENT1_ENABLE,
    output logic                              SEGMENT0_FRAME_START,
    output logic                              SEGMENT1_FRAME_START,
    output logic                              SEGMENT0_FRAME_END,
    output logic                              SEGMENT1_FRAME_END,
    output logic                              SEGMENT0_BAD_FRAME,
    output logic                              SEGMENT1_BAD_FRAME,
    output logic [`RX_EMPTY_W-1:0]            SEGMENT0_EMPTY_BYTES,
    output logic [`RX_EMPTY_W-1:0]            SEGMENT1_EMPTY_BYTES
);
    import rx_stream_pkg::*;

    // geometry is fixed by the packed types, so refuse anything else at elaboration
    if (SEG_W != `RX_SEG_W || SEG_COUNT != `RX_SEG_COUNT) begin : g_bad_geometry
        $error("segment geometry must be two segments of 64 bits");
    end

    // reset synchroniser for the active-high receive reset
    logic [`RX_RST_STAGES-1:0] rst_sync_r;
    wire                       rst_now = rst_sync_r[`RX_RST_STAGES-1];

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_sync_r <= '1;
        end else begin
            rst_sync_r <= {rst_sync_r[`RX_RST_STAGES-2:0], RX_RESET};
        end
    end

    // state: held word one cycle behind the decoder, frame open, code error seen
    seg_out_pair_t held_r;
    seg_out_pair_t held_nxt;
    seg_out_pair_t out_nxt;
    logic          open_r;
    logic          open_nxt;
    logic          code_r;
    logic          code_nxt;

    // a cycle with no input while a frame is open means the frame broke off
    wire in_any = IN_SEG[0].valid | IN_SEG[1].valid;
    wire gap    = open_r & ~in_any;
    wire last_i = held_r[1].en;

    // close a broken frame on the held word, else pass the held word on
    always_comb begin
        out_nxt = held_r;
        if (gap && (held_r[0].en || held_r[1].en)) begin
            out_nxt[last_i].last  = 1'b1;
            out_nxt[last_i].bad   = 1'b1;
            out_nxt[last_i].empty = `RX_EMPTY_NONE;
        end
    end

    // walk the incoming segments lower first, tracking frame boundaries
    always_comb begin
        logic open_v;
        logic code_v;
        logic keep;
        open_v   = gap ? 1'b0 : open_r;
        code_v   = gap ? 1'b0 : code_r;
        keep     = 1'b0;
        held_nxt = '0;
        for (int s = 0; s < `RX_SEG_COUNT; s++) begin
            keep = IN_SEG[s].valid & (open_v | IN_SEG[s].start);
            if (keep) begin
                held_nxt[s].en    = 1'b1;
                held_nxt[s].start = IN_SEG[s].start;
                held_nxt[s].last  = IN_SEG[s].last;
                held_nxt[s].data  = IN_SEG[s].data;
                held_nxt[s].bad   = IN_SEG[s].last & (IN_SEG[s].fcs_bad
                                  | IN_SEG[s].len_bad | IN_SEG[s].code_bad
                                  | code_v);
                held_nxt[s].empty = IN_SEG[s].last ? IN_SEG[s].empty
                                                   : `RX_EMPTY_NONE;
                code_v = code_v | IN_SEG[s].code_bad;
                open_v = ~IN_SEG[s].last;
                if (IN_SEG[s].last) begin
                    code_v = 1'b0;
                end
            end
        end
        open_nxt = open_v;
        code_nxt = code_v;
    end

    // pipeline state
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            held_r <= '0;
            open_r <= 1'b0;
            code_r <= 1'b0;
        end else if (rst_now) begin
            held_r <= '0;
            open_r <= 1'b0;
            code_r <= 1'b0;
        end else begin
            held_r <= held_nxt;
            open_r <= open_nxt;
            code_r <= code_nxt;
        end
    end

    // output flops, launched every edge with no stall input
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RX_DATA  <= '0;
            RX_VALID <= 1'b0;
        end else if (rst_now) begin
            RX_DATA  <= '0;
            RX_VALID <= 1'b0;
        end else begin
            RX_DATA  <= {out_nxt[1].data, out_nxt[0].data};
            RX_VALID <= out_nxt[0].en | out_nxt[1].en;
        end
    end

    // per-segment qualifier flops
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            SEGMENT0_ENABLE      <= 1'b0;
            SEGMENT1_ENABLE      <= 1'b0;
            SEGMENT0_FRAME_START <= 1'b0;
            SEGMENT1_FRAME_START <= 1'b0;
            SEGMENT0_FRAME_END   <= 1'b0;
            SEGMENT1_FRAME_END   <= 1'b0;
            SEGMENT0_BAD_FRAME   <= 1'b0;
            SEGMENT1_BAD_FRAME   <= 1'b0;
            SEGMENT0_EMPTY_BYTES <= `RX_EMPTY_NONE;
            SEGMENT1_EMPTY_BYTES <= `RX_EMPTY_NONE;
        end else if (rst_now) begin
            SEGMENT0_ENABLE      <= 1'b0;
            SEGMENT1_ENABLE      <= 1'b0;
            SEGMENT0_FRAME_START <= 1'b0;
            SEGMENT1_FRAME_START <= 1'b0;
            SEGMENT0_FRAME_END   <= 1'b0;
            SEGMENT1_FRAME_END   <= 1'b0;
            SEGMENT0_BAD_FRAME   <= 1'b0;
            SEGMENT1_BAD_FRAME   <= 1'b0;
            SEGMENT0_EMPTY_BYTES <= `RX_EMPTY_NONE;
            SEGMENT1_EMPTY_BYTES <= `RX_EMPTY_NONE;
        end else begin
            SEGMENT0_ENABLE      <= out_nxt[0].en;
            SEGMENT1_ENABLE      <= out_nxt[1].en;
            SEGMENT0_FRAME_START <= out_nxt[0].start;
            SEGMENT1_FRAME_START <= out_nxt[1].start;
            SEGMENT0_FRAME_END   <= out_nxt[0].last;
            SEGMENT1_FRAME_END   <= out_nxt[1].last;
            SEGMENT0_BAD_FRAME   <= out_nxt[0].bad;
            SEGMENT1_BAD_FRAME   <= out_nxt[1].bad;
            SEGMENT0_EMPTY_BYTES <= out_nxt[0].empty;
            SEGMENT1_EMPTY_BYTES <= out_nxt[1].empty;
        end
    end

endmodule

// ### tb/rx_stream_chk.sv
// checker for the segmented receive stream outputs
// assumes binding onto rx_segmented_frame_stream; two-edge output latency
`timescale 1ns/1ps
module rx_stream_chk import rx_stream_pkg::*; (
    // clock, resets, decoder side
    input wire logic         SYS_CLK, RESETN, RX_RESET,
    input wire seg_in_pair_t IN_SEG,
    // client stream
    input wire logic [127:0] RX_DATA,
    input wire logic         RX_VALID, SEGMENT0_ENABLE, SEGMENT1_ENABLE,
    input wire logic         SEGMENT0_FRAME_START, SEGMENT1_FRAME_START,
    input wire logic         SEGMENT0_FRAME_END, SEGMENT1_FRAME_END,
    input wire logic         SEGMENT0_BAD_FRAME, SEGMENT1_BAD_FRAME,
    input wire logic [2:0]   SEGMENT0_EMPTY_BYTES, SEGMENT1_EMPTY_BYTES
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN || RX_RESET);
    // frame still open in the upper segment, then the next beat
    sequence tail_open; SEGMENT1_ENABLE && !SEGMENT1_FRAME_END; endsequence
    sequence next_beat; ##1 (RX_VALID && SEGMENT0_ENABLE); endsequence
    valid_en_a: assert property (RX_VALID == (SEGMENT0_ENABLE | SEGMENT1_ENABLE))
        else $error("bus valid differs from segment enables");
    flags_en_a: assert property ((SEGMENT0_FRAME_START | SEGMENT0_FRAME_END) |-> SEGMENT0_ENABLE)
        else $error("segment flag without enable");
    bad_at_end_a: assert property (SEGMENT1_BAD_FRAME |-> SEGMENT1_FRAME_END && RX_VALID)
        else $error("bad flag outside ending beat");
    empty_final_a: assert property (!SEGMENT0_FRAME_END |-> SEGMENT0_EMPTY_BYTES == 3'h0)
        else $error("empty count on a non-final beat");
    low_latency_a: assert property (IN_SEG[0].valid && IN_SEG[0].start |-> ##2
        (SEGMENT0_FRAME_START && RX_DATA[63:0] == $past(IN_SEG[0].data, 2)))
        else $error("lower segment start or data wrong");
    high_latency_a: assert property (IN_SEG[1].valid && IN_SEG[1].start |-> ##2
        (SEGMENT1_FRAME_START && RX_DATA[127:64] == $past(IN_SEG[1].data, 2)))
        else $error("upper segment start or data wrong");
    bad_flag_a: assert property (IN_SEG[1].valid && IN_SEG[1].start && IN_SEG[1].last &&
        (IN_SEG[1].fcs_bad || IN_SEG[1].len_bad) |-> ##2 SEGMENT1_BAD_FRAME)
        else $error("failed frame not flagged bad");
    empty_pass_a: assert property (IN_SEG[1].valid && IN_SEG[1].start && IN_SEG[1].last |->
        ##2 (SEGMENT1_FRAME_END && SEGMENT1_EMPTY_BYTES == $past(IN_SEG[1].empty, 2)))
        else $error("empty count lost on ending beat");
    no_gap_a: assert property (tail_open |-> next_beat)
        else $error("idle gap inside a frame");
endmodule
bind rx_segmented_frame_stream rx_stream_chk chk (.*);

// ### tb/rx_client_model.sv
// client model: takes every beat, tallies ended and bad frames
// assumes the stream qualifiers of the device on the same clock
`timescale 1ns/1ps
module rx_client_model (
    input wire logic       clk, rst_n, valid,
    input wire logic [1:0] ends, bads,
    output logic [7:0]     frames, bad_frames
);
    // no ready exists, so every beat is taken as it comes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frames <= 8'h0;
            bad_frames <= 8'h0;
        end else if (valid) begin
            frames <= frames + 8'(ends[0]) + 8'(ends[1]);
            bad_frames <= bad_frames + 8'(ends[0] & bads[0]) + 8'(ends[1] & bads[1]);
        end
    end
endmodule

// ### tb/test_rx_segmented_frame_stream.sv
// bench for the segmented receive frame stream
// assumes package, checker and client model compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_rx_segmented_frame_stream;
    import rx_stream_pkg::*;
    logic          sys_clk = 0, resetn = 0, rx_reset = 0, rx_valid;
    seg_in_pair_t  in_seg = '0;
    seg_in_pair_t  stim [9] = '{default: '0};
    seg_out_pair_t want [9] = '{default: '0};
    logic [127:0]  rx_data;
    logic [1:0]    en, st, fin, bad;
    logic [2:0]    emp0, emp1;
    logic [7:0]    frames, bad_frames;
    int            err_total = 0, compares = 0, cycles = 0;
    wire seg_out_pair_t got = {{en[1], st[1], fin[1], bad[1], emp1, rx_data[127:64]},
                               {en[0], st[0], fin[0], bad[0], emp0, rx_data[63:0]}};
    rx_segmented_frame_stream uut (.SYS_CLK(sys_clk), .RESETN(resetn), .RX_RESET(rx_reset),
        .IN_SEG(in_seg), .RX_DATA(rx_data), .RX_VALID(rx_valid),
        .SEGMENT0_ENABLE(en[0]), .SEGMENT1_ENABLE(en[1]), .SEGMENT0_FRAME_START(st[0]),
        .SEGMENT1_FRAME_START(st[1]), .SEGMENT0_FRAME_END(fin[0]), .SEGMENT1_FRAME_END(fin[1]),
        .SEGMENT0_BAD_FRAME(bad[0]), .SEGMENT1_BAD_FRAME(bad[1]),
        .SEGMENT0_EMPTY_BYTES(emp0), .SEGMENT1_EMPTY_BYTES(emp1));
    rx_client_model client (.clk(sys_clk), .rst_n(resetn), .valid(rx_valid), .ends(fin),
        .bads(bad), .frames(frames), .bad_frames(bad_frames));
    // segment builders: flags, empty count, error bits, data byte
    function automatic seg_in_s si(logic [2:0] f, logic [2:0] e, logic [2:0] b, logic [7:0] n);
        return {f, e, b, {8{n}}};
    endfunction
    function automatic seg_out_s so(logic [3:0] f, logic [2:0] e, logic [7:0] n);
        return {f, e, {8{n}}};
    endfunction
    // clock and hang guard
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 100) begin
            err_total++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // rows {upper, lower}: in flags valid/start/last, out en/start/end/bad
    initial begin
        stim[0] = {si(3'h4, 3'h0, 3'h0, 8'h02), si(3'h6, 3'h0, 3'h0, 8'h01)};
        want[0] = {so(4'h8, 3'h0, 8'h02), so(4'hc, 3'h0, 8'h01)};
        stim[1] = {si(3'h6, 3'h0, 3'h0, 8'h04), si(3'h5, 3'h3, 3'h0, 8'h03)};
        want[1] = {so(4'hc, 3'h0, 8'h04), so(4'ha, 3'h3, 8'h03)};
        stim[2] = {si(3'h7, 3'h7, 3'h2, 8'h06), si(3'h5, 3'h0, 3'h4, 8'h05)};
        want[2] = {so(4'hf, 3'h7, 8'h06), so(4'hb, 3'h0, 8'h05)};
        stim[3] = {si(3'h4, 3'h0, 3'h0, 8'h08), si(3'h6, 3'h0, 3'h1, 8'h07)};
        want[3] = {so(4'h8, 3'h0, 8'h08), so(4'hc, 3'h0, 8'h07)};
        stim[4] = {si(3'h0, 3'h0, 3'h0, 8'h00), si(3'h5, 3'h5, 3'h0, 8'h09)};
        want[4] = {so(4'h0, 3'h0, 8'h00), so(4'hb, 3'h5, 8'h09)};
        stim[5] = {si(3'h0, 3'h0, 3'h0, 8'h00), si(3'h4, 3'h0, 3'h0, 8'h0a)};
        stim[6] = {si(3'h4, 3'h0, 3'h0, 8'h0c), si(3'h6, 3'h0, 3'h0, 8'h0b)};
        want[6] = {so(4'hb, 3'h0, 8'h0c), so(4'hc, 3'h0, 8'h0b)};
        #1 `CHK(got, want[8])
        repeat (2) @(posedge sys_clk);
        #1 resetn = 1;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 11; i++) begin
            @(posedge sys_clk);
            #1 in_seg = (i < 9) ? stim[i] : '0;
            if (i >= 2) `CHK(got, want[i - 2])
            if (i >= 2) `CHK(rx_valid, want[i - 2][0].en | want[i - 2][1].en)
        end
        `CHK(frames, 8'h05)
        `CHK(bad_frames, 8'h04)
        // receive reset in mid-frame drops it with no end flag; later middles are refused
        in_seg = stim[0];
        @(posedge sys_clk);
        #1 in_seg = {si(3'h4, 3'h0, 3'h0, 8'h0e), si(3'h4, 3'h0, 3'h0, 8'h0d)};
        rx_reset = 1;
        repeat (3) @(posedge sys_clk);
        #1 `CHK(got, want[8])
        rx_reset = 0;
        repeat (4) @(posedge sys_clk);
        #1 `CHK(got, want[8])
        finish_test();
    end
endmodule
